// >>> rtl/tfc_top.sv
// force-compare strobes, counter and compare registers of a 16-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "tfc_consts.svh"

module tfc_top
  import tfc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire tfc_bus_t BUS_I,
  input wire logic TICK_I,
  input wire logic [3:0] WAVE_MODE_SEL_I,
  input wire logic [1:0] OUT_ACTION_A_I,
  input wire logic [1:0] OUT_ACTION_B_I,
  input wire logic [1:0] OUT_ACTION_C_I,
  output logic [7:0] RDATA_O,
  output var tfc_wave_t WAVE_A_O,
  output var tfc_wave_t WAVE_B_O,
  output var tfc_wave_t WAVE_C_O
);

  // ==================================================
  // address decode
  logic wr_force;
  logic wr_cnt_lo;
  logic wr_hi;
  logic rd_cnt_lo;
  logic [2:0] wr_match_lo;

  assign wr_force = BUS_I.wr & (BUS_I.addr == `TFC_OFS_FORCE);
  assign wr_cnt_lo = BUS_I.wr & (BUS_I.addr == `TFC_OFS_CNT_LO);
  assign rd_cnt_lo = BUS_I.rd & (BUS_I.addr == `TFC_OFS_CNT_LO);
  // every high byte write lands in the shared temp register
  assign wr_hi = BUS_I.wr & ((BUS_I.addr == `TFC_OFS_CNT_HI) | (BUS_I.addr == `TFC_OFS_MA_HI) |
                             (BUS_I.addr == `TFC_OFS_MB_HI) | (BUS_I.addr == `TFC_OFS_MC_HI));
  assign wr_match_lo[0] = BUS_I.wr & (BUS_I.addr == `TFC_OFS_MA_LO);
  assign wr_match_lo[1] = BUS_I.wr & (BUS_I.addr == `TFC_OFS_MB_LO);
  assign wr_match_lo[2] = BUS_I.wr & (BUS_I.addr == `TFC_OFS_MC_LO);

  // ==================================================
  // shared temp high byte
  logic [7:0] temp_reg;
  logic [7:0] temp_next;
  logic [WIDTH-1:0] count_w;

  // low read of the counter snapshots its high byte for the later high read
  assign temp_next = wr_hi ? BUS_I.wdata :
                     rd_cnt_lo ? count_w[15:8] : temp_reg;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      temp_reg <= `TFC_RST8;
    end else begin
      temp_reg <= temp_next;
    end
  end

  // ==================================================
  // compare values, committed whole on the low byte write
  logic [WIDTH-1:0] match_value_reg [3];

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < 3; i++) begin
        match_value_reg[i] <= `TFC_RST16;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_match_lo[i]) begin
          match_value_reg[i] <= {temp_reg, BUS_I.wdata};
        end
      end
    end
  end

  // ==================================================
  // counter write blocks the next tick's compare
  logic block_reg;
  logic block_next;

  // a write mid-run can skip a match; software is expected to avoid it
  assign block_next = wr_cnt_lo ? 1'b1 : TICK_I ? 1'b0 : block_reg;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      block_reg <= 1'b0;
    end else begin
      block_reg <= block_next;
    end
  end

  // ==================================================
  // mode decode and force strobes
  logic non_pwm;
  logic ctc_mode;
  logic force_a;
  logic force_b;
  logic force_c;

  assign ctc_mode = (WAVE_MODE_SEL_I == `TFC_MODE_CTC_A) | (WAVE_MODE_SEL_I == `TFC_MODE_CTC_B);
  assign non_pwm = (WAVE_MODE_SEL_I == `TFC_MODE_NORMAL) | ctc_mode;
  // strobes live for the write cycle only and are never stored
  assign force_a = wr_force & BUS_I.wdata[`TFC_BIT_FORCE_A] & non_pwm;
  assign force_b = wr_force & BUS_I.wdata[`TFC_BIT_FORCE_B] & non_pwm;
  assign force_c = wr_force & BUS_I.wdata[`TFC_BIT_FORCE_C] & non_pwm;

  // ==================================================
  // counter and channels
  logic hit_a;
  logic hit_b;
  logic hit_c;

  tfc_counter #(.WIDTH(WIDTH)) u_counter (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .tick_i(TICK_I),
    .load_i(wr_cnt_lo),
    .load_val_i({temp_reg, BUS_I.wdata}),
    .clear_i(ctc_mode & hit_a),
    .count_o(count_w)
  );

  tfc_channel #(.WIDTH(WIDTH)) u_chan_a (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .count_i(count_w),
    .value_i(match_value_reg[0]),
    .tick_i(TICK_I),
    .block_i(block_reg),
    .force_i(force_a),
    .action_i(OUT_ACTION_A_I),
    .hit_o(hit_a),
    .wave_o(WAVE_A_O)
  );

  tfc_channel #(.WIDTH(WIDTH)) u_chan_b (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .count_i(count_w),
    .value_i(match_value_reg[1]),
    .tick_i(TICK_I),
    .block_i(block_reg),
    .force_i(force_b),
    .action_i(OUT_ACTION_B_I),
    .hit_o(hit_b),
    .wave_o(WAVE_B_O)
  );

  tfc_channel #(.WIDTH(WIDTH)) u_chan_c (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .count_i(count_w),
    .value_i(match_value_reg[2]),
    .tick_i(TICK_I),
    .block_i(block_reg),
    .force_i(force_c),
    .action_i(OUT_ACTION_C_I),
    .hit_o(hit_c),
    .wave_o(WAVE_C_O)
  );

  // ==================================================
  // read data
  logic [7:0] rd_mux;
  logic [7:0] rdata_reg;

  // force location and unmapped addresses read zero
  assign rd_mux = (BUS_I.addr == `TFC_OFS_CNT_LO) ? count_w[7:0] :
                  (BUS_I.addr == `TFC_OFS_CNT_HI) ? temp_reg :
                  (BUS_I.addr == `TFC_OFS_MA_LO) ? match_value_reg[0][7:0] :
                  (BUS_I.addr == `TFC_OFS_MA_HI) ? match_value_reg[0][15:8] :
                  (BUS_I.addr == `TFC_OFS_MB_LO) ? match_value_reg[1][7:0] :
                  (BUS_I.addr == `TFC_OFS_MB_HI) ? match_value_reg[1][15:8] :
                  (BUS_I.addr == `TFC_OFS_MC_LO) ? match_value_reg[2][7:0] :
                  (BUS_I.addr == `TFC_OFS_MC_HI) ? match_value_reg[2][15:8] : `TFC_ZERO8;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_reg <= `TFC_RST8;
    end else if (BUS_I.rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign RDATA_O = rdata_reg;

  // ==================================================
  // assertions
  sequence s_cnt_write;
    wr_cnt_lo;
  endsequence

  sequence s_hi_then_lo_a;
    (BUS_I.wr & (BUS_I.addr == `TFC_OFS_MA_HI)) ##1 wr_match_lo[0];
  endsequence

  property p_force_pwm_ignored;
    @(posedge MCLK_I) disable iff (RST_I)
      (wr_force & BUS_I.wdata[`TFC_BIT_FORCE_A] & !non_pwm & !hit_a) |=> $stable(WAVE_A_O.pin);
  endproperty
  a_force_pwm_ignored: assert property (p_force_pwm_ignored) else $error("force acted in pwm mode");

  property p_force_sets_high;
    @(posedge MCLK_I) disable iff (RST_I)
      (force_b & (OUT_ACTION_B_I == `TFC_ACT_HIGH)) |=> WAVE_B_O.pin & WAVE_B_O.oe;
  endproperty
  a_force_sets_high: assert property (p_force_sets_high) else $error("forced set did not drive high");

  property p_force_no_event;
    @(posedge MCLK_I) disable iff (RST_I)
      (force_a & !hit_a) |=> !WAVE_A_O.evt;
  endproperty
  a_force_no_event: assert property (p_force_no_event) else $error("forced match raised an event");

  property p_force_no_clear;
    @(posedge MCLK_I) disable iff (RST_I)
      (force_a & ctc_mode & !hit_a & !wr_cnt_lo & TICK_I) |=> (count_w == $past(count_w) + 16'h0001);
  endproperty
  a_force_no_clear: assert property (p_force_no_clear) else $error("forced match cleared counter");

  property p_force_reads_zero;
    @(posedge MCLK_I) disable iff (RST_I)
      (BUS_I.rd & (BUS_I.addr == `TFC_OFS_FORCE)) |=> (RDATA_O == `TFC_ZERO8);
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force location read nonzero");

  property p_cnt_load;
    @(posedge MCLK_I) disable iff (RST_I)
      s_cnt_write |=> (count_w == {$past(temp_reg), $past(BUS_I.wdata)});
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("counter write not taken whole");

  property p_cnt_lo_read_latch;
    @(posedge MCLK_I) disable iff (RST_I)
      rd_cnt_lo |=> (temp_reg == $past(count_w[15:8])) & (RDATA_O == $past(count_w[7:0]));
  endproperty
  a_cnt_lo_read_latch: assert property (p_cnt_lo_read_latch) else $error("low read did not latch high");

  property p_match_atomic;
    @(posedge MCLK_I) disable iff (RST_I)
      s_hi_then_lo_a |=> (match_value_reg[0] == {$past(BUS_I.wdata, 2), $past(BUS_I.wdata)});
  endproperty
  a_match_atomic: assert property (p_match_atomic) else $error("compare value half updated");

  property p_block_after_write;
    @(posedge MCLK_I) disable iff (RST_I)
      (block_reg & TICK_I) |=> !WAVE_A_O.evt & !WAVE_B_O.evt & !WAVE_C_O.evt;
  endproperty
  a_block_after_write: assert property (p_block_after_write) else $error("match seen after counter write");

  property p_real_match_event;
    @(posedge MCLK_I) disable iff (RST_I)
      (TICK_I & !block_reg & (count_w == match_value_reg[1])) |=> WAVE_B_O.evt;
  endproperty
  a_real_match_event: assert property (p_real_match_event) else $error("real match missed");

  property p_toggle;
    @(posedge MCLK_I) disable iff (RST_I)
      (hit_a & !force_a & (OUT_ACTION_A_I == `TFC_ACT_TOGGLE)) |=> (WAVE_A_O.pin != $past(WAVE_A_O.pin));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle action did not toggle");

  property p_pin_c_low;
    @(posedge MCLK_I) disable iff (RST_I)
      (hit_c & (OUT_ACTION_C_I == `TFC_ACT_LOW)) |=> !WAVE_C_O.pin ##1 (WAVE_C_O.oe == ($past(OUT_ACTION_C_I) != `TFC_ACT_OFF));
  endproperty
  a_pin_c_low: assert property (p_pin_c_low) else $error("channel c pin not cleared");

  property p_ctc_b_force;
    @(posedge MCLK_I) disable iff (RST_I)
      ((WAVE_MODE_SEL_I == `TFC_MODE_CTC_B) & wr_force & BUS_I.wdata[`TFC_BIT_FORCE_B] &
       (OUT_ACTION_B_I == `TFC_ACT_LOW)) |=> !WAVE_B_O.pin;
  endproperty
  a_ctc_b_force: assert property (p_ctc_b_force) else $error("force ignored in clear-on-match mode");

endmodule
`default_nettype wire

// >>> rtl/tfc_consts.svh
// offsets, bit positions, codes and reset values of the force/count/compare block
`ifndef TFC_CONSTS_SVH
`define TFC_CONSTS_SVH

// ==================================================
// register offsets on the 8-bit I/O port
`define TFC_OFS_FORCE 8'h92
`define TFC_OFS_CNT_LO 8'h94
`define TFC_OFS_CNT_HI 8'h95
`define TFC_OFS_MA_LO 8'h98
`define TFC_OFS_MA_HI 8'h99
`define TFC_OFS_MB_LO 8'h9A
`define TFC_OFS_MB_HI 8'h9B
`define TFC_OFS_MC_LO 8'h9C
`define TFC_OFS_MC_HI 8'h9D

// ==================================================
// bit positions of the force strobes
`define TFC_BIT_FORCE_A 7
`define TFC_BIT_FORCE_B 6
`define TFC_BIT_FORCE_C 5

// ==================================================
// reset values and read-as-zero value
`define TFC_RST8 8'h00
`define TFC_RST16 16'h0000
`define TFC_ZERO8 8'h00

// ==================================================
// output action codes
`define TFC_ACT_OFF 2'h0
`define TFC_ACT_TOGGLE 2'h1
`define TFC_ACT_LOW 2'h2
`define TFC_ACT_HIGH 2'h3

// ==================================================
// waveform mode codes without pwm
`define TFC_MODE_NORMAL 4'h0
`define TFC_MODE_CTC_A 4'h4
`define TFC_MODE_CTC_B 4'hC

`endif

// >>> rtl/tfc_pkg.sv
// shared types of the force/count/compare block
`default_nettype none
package tfc_pkg;

  // ==================================================
  // one access on the 8-bit I/O port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tfc_bus_t;

  // ==================================================
  // state of one waveform output
  typedef struct packed {
    logic pin;
    logic oe;
    logic evt;
  } tfc_wave_t;

endpackage
`default_nettype wire

// >>> rtl/tfc_counter.sv
// 16-bit up counter with software load and clear-on-match
`timescale 1ns/1ps
`default_nettype none
`include "tfc_consts.svh"

module tfc_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_val_i,
  input wire logic clear_i,
  output logic [WIDTH-1:0] count_o
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // load wins over clear, clear wins over counting
  assign count_next = load_i ? load_val_i :
                      clear_i ? '0 :
                      tick_i ? count_reg + {{(WIDTH-1){1'b0}}, 1'b1} : count_reg;

  // counter storage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_o = count_reg;

endmodule
`default_nettype wire

// >>> rtl/tfc_channel.sv
// one compare channel: match detect and waveform output
`timescale 1ns/1ps
`default_nettype none
`include "tfc_consts.svh"

module tfc_channel
  import tfc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] count_i,
  input wire logic [WIDTH-1:0] value_i,
  input wire logic tick_i,
  input wire logic block_i,
  input wire logic force_i,
  input wire logic [1:0] action_i,
  output logic hit_o,
  output var tfc_wave_t wave_o
);

  logic pin_reg;
  logic pin_next;
  logic oe_reg;
  logic evt_reg;
  logic fire;

  // real match: timer tick, equal value, not blocked by a counter write
  assign hit_o = tick_i & ~block_i & (count_i == value_i);
  // forced match acts on the pin like a real one
  assign fire = hit_o | force_i;

  // output action chosen by the current action code
  assign pin_next = !fire ? pin_reg :
                    (action_i == `TFC_ACT_TOGGLE) ? ~pin_reg :
                    (action_i == `TFC_ACT_LOW) ? 1'b0 :
                    (action_i == `TFC_ACT_HIGH) ? 1'b1 : pin_reg;

  // pin, drive enable and match event pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
      evt_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      oe_reg <= (action_i != `TFC_ACT_OFF);
      evt_reg <= hit_o;
    end
  end

  assign wave_o = '{pin: pin_reg, oe: oe_reg, evt: evt_reg};

endmodule
`default_nettype wire

// >>> verif/tb_tfc_top.sv
// self-checking testbench of the force/count/compare block
`timescale 1ns/1ps
`default_nettype none
`include "tfc_consts.svh"

module tb_tfc_top
  import tfc_pkg::*;
;
  logic mclk;
  logic rst;
  tfc_bus_t bus;
  logic tick;
  logic [3:0] mode;
  logic [1:0] act;
  logic [7:0] rdata;
  tfc_wave_t wv [3];
  int failures;
  int check_count;

  // ==================================================
  // design under test
  tfc_top i_dut (
    .MCLK_I(mclk),
    .RST_I(rst),
    .BUS_I(bus),
    .TICK_I(tick),
    .WAVE_MODE_SEL_I(mode),
    .OUT_ACTION_A_I(act),
    .OUT_ACTION_B_I(act),
    .OUT_ACTION_C_I(act),
    .RDATA_O(rdata),
    .WAVE_A_O(wv[0]),
    .WAVE_B_O(wv[1]),
    .WAVE_C_O(wv[2])
  );

  // ==================================================
  // 200 mhz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ==================================================
  // closing, comparison and bus tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // request raised after a falling edge, taken at the rising edge, dropped at the next falling edge
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus.addr = a;
    bus.wdata = d;
    bus.wr = 1'b1;
    @(negedge mclk);
    bus.wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge mclk);
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge mclk);
    bus.rd = 1'b0;
    chk(rdata, exp, what);
  endtask

  // high byte goes to the shared temp first, low byte commits both; back to back, strobe held
  task automatic wr16(input logic [7:0] hi_a, input logic [7:0] lo_a, input logic [15:0] v);
    @(negedge mclk);
    bus.addr = hi_a;
    bus.wdata = v[15:8];
    bus.wr = 1'b1;
    @(negedge mclk);
    bus.addr = lo_a;
    bus.wdata = v[7:0];
    @(negedge mclk);
    bus.wr = 1'b0;
  endtask

  task automatic do_tick();
    @(negedge mclk);
    tick = 1'b1;
    @(negedge mclk);
    tick = 1'b0;
  endtask

  task automatic chk_evt(input logic [2:0] exp, input string what);
    chk({5'h00, wv[0].evt, wv[1].evt, wv[2].evt}, {5'h00, exp}, what);
  endtask

  task automatic chk_pins(input logic [2:0] exp, input string what);
    chk({5'h00, wv[0].pin, wv[1].pin, wv[2].pin}, {5'h00, exp}, what);
  endtask

  // ==================================================
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  // ==================================================
  // main sequence
  initial begin
    logic [3:0] modes [6];
    logic [1:0] acts [6];
    logic exp_pin [6];
    modes = '{4'h0, 4'hC, 4'h4, 4'h1, 4'hE, 4'h0};
    acts = '{2'h3, 2'h2, 2'h1, 2'h2, 2'h2, 2'h0};
    exp_pin = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    failures = 0;
    check_count = 0;
    rst = 1'b1;
    bus = '0;
    tick = 1'b0;
    mode = 4'h1;
    act = 2'h0;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    // set action high so an honoured force in pwm mode would show on the pins
    act = 2'h3;
    // reset values and an unmapped place
    rd_chk(`TFC_OFS_FORCE, 8'h00, "force reset");
    rd_chk(`TFC_OFS_MA_LO, 8'h00, "a lo reset");
    rd_chk(`TFC_OFS_MA_HI, 8'h00, "a hi reset");
    rd_chk(`TFC_OFS_MB_LO, 8'h00, "b lo reset");
    rd_chk(`TFC_OFS_MB_HI, 8'h00, "b hi reset");
    rd_chk(`TFC_OFS_MC_HI, 8'h00, "c hi reset");
    rd_chk(`TFC_OFS_CNT_LO, 8'h00, "cnt lo reset");
    rd_chk(`TFC_OFS_CNT_HI, 8'h00, "cnt hi reset");
    rd_chk(8'h93, 8'h00, "unmapped");
    // all force bits in a pwm mode: ignored, reads zero
    bus_wr(`TFC_OFS_FORCE, 8'hFF);
    rd_chk(`TFC_OFS_FORCE, 8'h00, "force readback");
    chk_pins(3'b000, "pwm force pins");
    // a lone high write must not reach the compare register
    bus_wr(`TFC_OFS_MB_HI, 8'h5A);
    rd_chk(`TFC_OFS_MB_HI, 8'h00, "b hi before commit");
    bus_wr(`TFC_OFS_MB_LO, 8'h3C);
    rd_chk(`TFC_OFS_MB_HI, 8'h5A, "b hi after commit");
    rd_chk(`TFC_OFS_MB_LO, 8'h3C, "b lo after commit");
    // temp written through channel a high is committed by channel b low
    bus_wr(`TFC_OFS_MA_HI, 8'h56);
    bus_wr(`TFC_OFS_MB_LO, 8'h78);
    rd_chk(`TFC_OFS_MB_HI, 8'h56, "shared temp");
    rd_chk(`TFC_OFS_MA_HI, 8'h00, "a untouched");
    wr16(`TFC_OFS_MA_HI, `TFC_OFS_MA_LO, 16'hA5C3);
    rd_chk(`TFC_OFS_MA_LO, 8'hC3, "a lo");
    rd_chk(`TFC_OFS_MA_HI, 8'hA5, "a hi");
    // counter written while stopped
    wr16(`TFC_OFS_CNT_HI, `TFC_OFS_CNT_LO, 16'h1234);
    rd_chk(`TFC_OFS_CNT_LO, 8'h34, "cnt lo");
    rd_chk(`TFC_OFS_CNT_HI, 8'h12, "cnt hi");
    // force each channel through modes and actions
    for (int ch = 0; ch < 3; ch++) begin
      for (int k = 0; k < 6; k++) begin
        @(negedge mclk);
        mode = modes[k];
        act = acts[k];
        bus_wr(`TFC_OFS_FORCE, 8'h80 >> ch);
        chk({7'h00, wv[ch].pin}, {7'h00, exp_pin[k]}, "forced pin");
        chk({7'h00, wv[ch].oe}, {7'h00, acts[k] != 2'h0}, "pin enable");
        chk({7'h00, wv[ch].evt}, 8'h00, "forced evt");
      end
    end
    // forced matches left the counter alone
    rd_chk(`TFC_OFS_CNT_LO, 8'h34, "cnt after force lo");
    rd_chk(`TFC_OFS_CNT_HI, 8'h12, "cnt after force hi");
    // drive all pins low, then real matches set b and c; the tick at a's match is blocked
    @(negedge mclk);
    mode = 4'h0;
    act = 2'h2;
    bus_wr(`TFC_OFS_FORCE, 8'hE0);
    chk_pins(3'b000, "pins low");
    @(negedge mclk);
    act = 2'h3;
    wr16(`TFC_OFS_MA_HI, `TFC_OFS_MA_LO, 16'h0010);
    wr16(`TFC_OFS_MB_HI, `TFC_OFS_MB_LO, 16'h0011);
    wr16(`TFC_OFS_MC_HI, `TFC_OFS_MC_LO, 16'h0012);
    wr16(`TFC_OFS_CNT_HI, `TFC_OFS_CNT_LO, 16'h0010);
    do_tick();
    chk_evt(3'b000, "blocked tick");
    chk_pins(3'b000, "blocked pins");
    do_tick();
    chk_evt(3'b010, "b match");
    chk_pins(3'b010, "b pin");
    do_tick();
    chk_evt(3'b001, "c match");
    chk_pins(3'b011, "c pin");
    // clear-on-match with channel a as top
    @(negedge mclk);
    mode = 4'h4;
    wr16(`TFC_OFS_MA_HI, `TFC_OFS_MA_LO, 16'h0014);
    do_tick();
    chk_evt(3'b000, "no match at 13");
    do_tick();
    chk_evt(3'b100, "a match");
    chk_pins(3'b111, "a pin");
    rd_chk(`TFC_OFS_CNT_LO, 8'h00, "cleared lo");
    rd_chk(`TFC_OFS_CNT_HI, 8'h00, "cleared hi");
    // force a in the same cycle as a tick: toggles the pin, counter still steps
    @(negedge mclk);
    act = 2'h1;
    wr16(`TFC_OFS_CNT_HI, `TFC_OFS_CNT_LO, 16'h0013);
    @(negedge mclk);
    bus.addr = `TFC_OFS_FORCE;
    bus.wdata = 8'h80;
    bus.wr = 1'b1;
    tick = 1'b1;
    @(negedge mclk);
    bus.wr = 1'b0;
    tick = 1'b0;
    chk_pins(3'b011, "forced toggle");
    chk_evt(3'b000, "forced with tick");
    rd_chk(`TFC_OFS_CNT_LO, 8'h14, "force did not clear");
    do_tick();
    chk_evt(3'b100, "a toggle match");
    chk_pins(3'b111, "a toggled back");
    // a blocked tick hides a b match, then c clears its pin
    @(negedge mclk);
    act = 2'h2;
    wr16(`TFC_OFS_CNT_HI, `TFC_OFS_CNT_LO, 16'h0011);
    do_tick();
    chk_evt(3'b000, "b match blocked");
    do_tick();
    chk_evt(3'b001, "c match low");
    chk_pins(3'b110, "c pin low");
    rd_chk(`TFC_OFS_MC_LO, 8'h12, "c lo");
    rd_chk(`TFC_OFS_MC_HI, 8'h00, "c hi");
    tally_and_finish();
  end
endmodule

`default_nettype wire
